// ===== verilog/mss_pkg.sv
// constants and carrier types for the multistage speed sequencer
// What this block does
// - sequencer runs only while drive control mode setting equals 3
// - up to eight speed segments are stored and sequenced, numbered one to eight
// - mode 0 runs segments upward from one and stops after the last
// - mode 1 runs segments upward and wraps to one until enable drops
// - mode 2 outputs the selected segment speed, ignoring run times
// - select bits form a binary value, bit2 most significant; segment is value+1
// - enable low stops the sequence; enable high again restarts at segment one in modes 0 and 1, at the selected segment in mode 2
// - last segment setting 1 to 8 bounds modes 0 and 1 only
// - run time unit setting: 0 milliseconds, 1 seconds, 2 minutes
// - three acceleration times 0 to 10000 ms, zero to rated speed
// - three deceleration times 0 to 10000 ms, rated speed to zero
// - each segment holds a signed speed target of -3000 to 3000 rpm
// - each segment holds a run time 0 to 30000 in the chosen unit
// - ramp select 0 steps at once; 1 to 3 use the matching time pair
// - segments two to eight carry the same settings as segment one
// - after reset every segment has ramp select 0, no ramp
package mss_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS         = 1000000;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_S      = 1000;
    localparam int MS_PER_MIN    = 60000;

    // ------------------------------------------------------------
    // settings encodings and limits
    // ------------------------------------------------------------
    localparam logic [3:0]  INTERNAL_SPEED_MODE = 4'h3;
    localparam logic [1:0]  SEQ_SINGLE          = 2'h0;
    localparam logic [1:0]  SEQ_CYCLIC          = 2'h1;
    localparam logic [1:0]  SEQ_SELECT          = 2'h2;
    localparam logic [1:0]  UNIT_MS             = 2'h0;
    localparam logic [1:0]  UNIT_S              = 2'h1;
    localparam logic [1:0]  UNIT_MIN            = 2'h2;
    localparam logic [1:0]  RAMP_NONE           = 2'h0;
    localparam int          SEG_COUNT           = 8;
    localparam logic [3:0]  LAST_SEG_MAX        = 4'h8;
    localparam logic [15:0] RATED_RPM           = 16'h0bb8;

    // ------------------------------------------------------------
    // segment reset values
    // ------------------------------------------------------------
    localparam logic signed [15:0] SEG_SPEED_RST = 16'sh000a;
    localparam logic [14:0]        SEG_TIME_RST  = 15'h0064;
    localparam logic [1:0]         SEG_RAMP_RST  = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DONE,
        ST_SELECT
    } mss_fsm_t;

    typedef struct packed {
        logic signed [15:0] speed;
        logic [14:0]        run_time;
        logic [1:0]         ramp_sel;
    } mss_seg_cfg_t;

    typedef struct packed {
        logic [2:0][13:0] accel;
        logic [2:0][13:0] decel;
    } mss_ramp_times_t;

    typedef struct packed {
        logic [3:0] drive_control_mode_setting;
        logic [1:0] sequence_mode_setting;
        logic [3:0] last_segment_setting;
        logic [1:0] run_time_unit_setting;
    } mss_settings_t;

endpackage : mss_pkg

// ===== verilog/mss_sequencer.sv
// multistage speed sequencer: segment table, sequencing and ramping
`timescale 1ns/1ps
module mss_sequencer #(
    parameter int P_CYC_PER_MS = mss_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst,
    // controller inputs
    input  wire logic                   i_enable,
    input  wire logic                   i_segment_select_bit0,
    input  wire logic                   i_segment_select_bit1,
    input  wire logic                   i_segment_select_bit2,
    // settings
    input  wire mss_pkg::mss_settings_t   i_settings,
    input  wire mss_pkg::mss_ramp_times_t i_ramp_times,
    // segment table write
    input  wire logic                   i_cfg_wr,
    input  wire logic [2:0]             i_cfg_index,
    input  wire mss_pkg::mss_seg_cfg_t  i_cfg_data,
    // status and command
    output logic signed [15:0]          o_speed_cmd,
    output logic [2:0]                  o_segment_index,
    output logic                        o_running,
    output logic                        o_sequence_done
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mss_pkg::mss_fsm_t                   fsm;
        logic [mss_pkg::SEG_COUNT-1:0][32:0] table_q;
        logic [2:0]                          seg;
        logic [15:0]                         ms_cnt;
        logic [15:0]                         unit_cnt;
        logic [14:0]                         run_cnt;
        logic [29:0]                         ramp_acc;
        logic signed [15:0]                  speed;
        logic                                running;
        logic                                done;
    } mss_state_t;

    mss_state_t st;
    mss_state_t next_st;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic                  active;
        logic                  ms_tick;
        logic                  unit_tick;
        logic                  enter;
        logic [15:0]           unit_len;
        logic [2:0]            sel_idx;
        logic [2:0]            last_idx;
        mss_pkg::mss_seg_cfg_t cur;
        logic signed [15:0]    target;
        logic                  accel;
        logic [13:0]           ramp_ms;
        logic [29:0]           thr;
        logic [29:0]           acc_sum;

        next_st   = st;
        enter     = 1'b0;
        unit_tick = 1'b0;
        target    = 16'sh0000;
        active    = 1'b0;
        ms_tick   = 1'b0;
        unit_len  = 16'h0001;
        sel_idx   = 3'h0;
        last_idx  = 3'h0;
        cur       = '0;
        accel     = 1'b0;
        ramp_ms   = 14'h0;
        thr       = 30'h0;
        acc_sum   = 30'h0;

        // segment table storage, same fields for every segment
        if (i_cfg_wr) begin
            next_st.table_q[i_cfg_index] = i_cfg_data;
        end

        active = i_enable && (i_settings.drive_control_mode_setting ==
                 mss_pkg::INTERNAL_SPEED_MODE);
        sel_idx = {i_segment_select_bit2, i_segment_select_bit1,
                   i_segment_select_bit0};

        // a zero or oversize setting is pulled into the legal 1..8 range
        if (i_settings.last_segment_setting == 4'h0) begin
            last_idx = 3'h0;
        end else if (i_settings.last_segment_setting > mss_pkg::LAST_SEG_MAX) begin
            last_idx = 3'h7;
        end else begin
            last_idx = 3'(i_settings.last_segment_setting - 4'h1);
        end

        // time base: ms prescaler, then the selected unit
        unique case (i_settings.run_time_unit_setting)
            mss_pkg::UNIT_S:   unit_len = 16'(mss_pkg::MS_PER_S);
            mss_pkg::UNIT_MIN: unit_len = 16'(mss_pkg::MS_PER_MIN);
            default:           unit_len = 16'h0001;
        endcase
        ms_tick = (st.ms_cnt == 16'(P_CYC_PER_MS - 1));
        next_st.ms_cnt = ms_tick ? 16'h0000 : st.ms_cnt + 16'h0001;
        if (ms_tick) begin
            if (st.unit_cnt + 16'h0001 >= unit_len) begin
                next_st.unit_cnt = 16'h0000;
                unit_tick        = 1'b1;
            end else begin
                next_st.unit_cnt = st.unit_cnt + 16'h0001;
            end
        end
        if (unit_tick && st.run_cnt != 15'h7fff) begin
            next_st.run_cnt = st.run_cnt + 15'h0001;
        end

        cur = st.table_q[st.seg];

        // ------------------------------------------------------------
        // sequencing
        // ------------------------------------------------------------
        unique case (st.fsm)
            mss_pkg::ST_IDLE: begin
                if (active) begin
                    if (i_settings.sequence_mode_setting ==
                        mss_pkg::SEQ_SELECT) begin
                        next_st.fsm = mss_pkg::ST_SELECT;
                        next_st.seg = sel_idx;
                    end else begin
                        next_st.fsm = mss_pkg::ST_RUN;
                        next_st.seg = 3'h0;
                        enter       = 1'b1;
                    end
                end
            end
            mss_pkg::ST_RUN: begin
                target = cur.speed;
                if (!active) begin
                    next_st.fsm = mss_pkg::ST_IDLE;
                end else if (i_settings.sequence_mode_setting ==
                             mss_pkg::SEQ_SELECT) begin
                    next_st.fsm = mss_pkg::ST_SELECT;
                    next_st.seg = sel_idx;
                end else if (st.run_cnt >= cur.run_time) begin
                    if (st.seg >= last_idx) begin
                        if (i_settings.sequence_mode_setting ==
                            mss_pkg::SEQ_CYCLIC) begin
                            next_st.seg = 3'h0;
                            enter       = 1'b1;
                        end else begin
                            next_st.fsm = mss_pkg::ST_DONE;
                        end
                    end else begin
                        next_st.seg = st.seg + 3'h1;
                        enter       = 1'b1;
                    end
                end
            end
            mss_pkg::ST_DONE: begin
                // stays stopped until enable drops and returns
                if (!active) begin
                    next_st.fsm = mss_pkg::ST_IDLE;
                end
            end
            mss_pkg::ST_SELECT: begin
                target      = cur.speed;
                next_st.seg = sel_idx;
                if (!active || i_settings.sequence_mode_setting !=
                    mss_pkg::SEQ_SELECT) begin
                    next_st.fsm = mss_pkg::ST_IDLE;
                end
            end
        endcase

        // count restarts on every segment entry in modes 0 and 1; mode 2 select changes do not restart it
        if (enter) begin
            next_st.ms_cnt   = 16'h0000;
            next_st.unit_cnt = 16'h0000;
            next_st.run_cnt  = 15'h0000;
            next_st.ramp_acc = 30'h0;
        end

        // ------------------------------------------------------------
        // ramp: one rpm step at most per cycle, rated speed per ramp time; ramp select 0 or a zero ramp time steps at once
        // ------------------------------------------------------------
        // moving away from zero is acceleration, toward zero deceleration
        accel = (st.speed >= 16'sh0000 && target > st.speed) ||
                (st.speed <= 16'sh0000 && target < st.speed);
        if (cur.ramp_sel == mss_pkg::RAMP_NONE) begin
            ramp_ms = 14'h0;
        end else if (accel) begin
            ramp_ms = i_ramp_times.accel[cur.ramp_sel - 2'h1];
        end else begin
            ramp_ms = i_ramp_times.decel[cur.ramp_sel - 2'h1];
        end
        // at the default cycles per ms, rated speed stays below one ms worth of cycles, so the
        // accumulator crosses the threshold at most once per cycle
        thr     = 30'(ramp_ms * P_CYC_PER_MS);
        acc_sum = st.ramp_acc + 30'(mss_pkg::RATED_RPM);
        if (st.speed == target) begin
            next_st.ramp_acc = 30'h0;
        end else if (ramp_ms == 14'h0) begin
            next_st.speed    = target;
            next_st.ramp_acc = 30'h0;
        end else if (acc_sum >= thr) begin
            next_st.ramp_acc = acc_sum - thr;
            if (target > st.speed) begin
                next_st.speed = st.speed + 16'sh0001;
            end else begin
                next_st.speed = st.speed - 16'sh0001;
            end
        end else begin
            next_st.ramp_acc = acc_sum;
        end

        next_st.running = (next_st.fsm == mss_pkg::ST_RUN) ||
                          (next_st.fsm == mss_pkg::ST_SELECT);
        next_st.done    = (next_st.fsm == mss_pkg::ST_DONE);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            next_st_reset_loop: for (int i = 0; i < mss_pkg::SEG_COUNT;
                                     i++) begin
                st.table_q[i] <= {mss_pkg::SEG_SPEED_RST,
                                  mss_pkg::SEG_TIME_RST,
                                  mss_pkg::SEG_RAMP_RST};
            end
            st.fsm      <= mss_pkg::ST_IDLE;
            st.seg      <= 3'h0;
            st.ms_cnt   <= 16'h0000;
            st.unit_cnt <= 16'h0000;
            st.run_cnt  <= 15'h0000;
            st.ramp_acc <= 30'h0;
            st.speed    <= 16'sh0000;
            st.running  <= 1'b0;
            st.done     <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign o_speed_cmd     = st.speed;
    assign o_segment_index = st.seg;
    assign o_running       = st.running;
    assign o_sequence_done = st.done;

endmodule : mss_sequencer

// ===== sim/mss_sequencer_props.sv
// property checker bound to the speed sequencer ports
`timescale 1ns/1ps
module mss_sequencer_props #(
    parameter int P_CYC_PER_MS = mss_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic                     i_clk_sys,
    input wire logic                     i_rst,
    // controller and settings
    input wire logic                     i_enable,
    input wire logic                     i_segment_select_bit0,
    input wire logic                     i_segment_select_bit1,
    input wire logic                     i_segment_select_bit2,
    input wire mss_pkg::mss_settings_t   i_settings,
    input wire mss_pkg::mss_ramp_times_t i_ramp_times,
    // table write
    input wire logic                     i_cfg_wr,
    input wire logic [2:0]               i_cfg_index,
    input wire mss_pkg::mss_seg_cfg_t    i_cfg_data,
    // outputs
    input wire logic signed [15:0]       o_speed_cmd,
    input wire logic [2:0]               o_segment_index,
    input wire logic                     o_running,
    input wire logic                     o_sequence_done
);
    logic [2:0] sel;
    logic       act;
    logic [1:0] sq;
    assign sel = {i_segment_select_bit2, i_segment_select_bit1,
                  i_segment_select_bit0};
    assign act = i_enable && i_settings.drive_control_mode_setting == 4'h3;
    assign sq  = i_settings.sequence_mode_setting;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_mode_gate: assert property (
        i_settings.drive_control_mode_setting != 4'h3 |=> !o_running)
        else $error("running outside internal speed mode");
    a_enable_stop: assert property (
        !i_enable && sq != 2'h2 |=> !o_running)
        else $error("still running after enable dropped");
    a_start_first: assert property (
        $rose(o_running) && $past(sq) != 2'h2 |-> o_segment_index == 3'h0)
        else $error("sequence did not start at segment one");
    a_run_start: assert property (
        act && !o_running && !o_sequence_done |=> o_running)
        else $error("enable did not start the sequencer");
    a_select_index: assert property (
        (act && sq == 2'h2 && $stable(sel)) [*3] |-> o_segment_index == sel)
        else $error("selected segment does not follow select bits");
    a_done_idle: assert property (
        o_sequence_done |-> !o_running)
        else $error("running while sequence done");
    a_done_hold: assert property (
        o_sequence_done && act && sq == 2'h0 |=> o_sequence_done)
        else $error("single pass restarted without enable drop");
    a_index_step: assert property (
        o_running && $past(o_running) && $past(sq) != 2'h2
        && $changed(o_segment_index) |-> o_segment_index == 3'h0
        || o_segment_index == $past(o_segment_index) + 3'h1)
        else $error("segment order not ascending");
    a_last_bound: assert property (
        o_running && $past(sq) != 2'h2
        && $past(i_settings.last_segment_setting) inside {[4'h1:4'h8]}
        |-> {1'b0, o_segment_index} < $past(i_settings.last_segment_setting))
        else $error("segment beyond last segment setting");
    a_reset_clear: assert property (
        $fell(i_rst) |-> o_speed_cmd == 16'sh0000 && !o_running
        && o_segment_index == 3'h0 && !o_sequence_done)
        else $error("outputs not cleared by reset");
endmodule : mss_sequencer_props

bind mss_sequencer mss_sequencer_props #(.P_CYC_PER_MS(P_CYC_PER_MS))
    mss_sequencer_props_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_enable(i_enable), .i_segment_select_bit0(i_segment_select_bit0),
    .i_segment_select_bit1(i_segment_select_bit1),
    .i_segment_select_bit2(i_segment_select_bit2),
    .i_settings(i_settings), .i_ramp_times(i_ramp_times),
    .i_cfg_wr(i_cfg_wr), .i_cfg_index(i_cfg_index), .i_cfg_data(i_cfg_data),
    .o_speed_cmd(o_speed_cmd), .o_segment_index(o_segment_index),
    .o_running(o_running), .o_sequence_done(o_sequence_done));

// ===== sim/mss_ctrl_model.sv
// external controller model: enable and segment select lines
`timescale 1ns/1ps
module mss_ctrl_model (
    // clock
    input  wire logic       i_clk_sys,
    // requests from the bench
    input  wire logic       i_en_req,
    input  wire logic [2:0] i_sel_req,
    // lines to the sequencer
    output logic            o_enable,
    output logic            o_segment_select_bit0,
    output logic            o_segment_select_bit1,
    output logic            o_segment_select_bit2
);
    initial begin
        o_enable = 1'b0;
        {o_segment_select_bit2, o_segment_select_bit1} = 2'h0;
        o_segment_select_bit0 = 1'b0;
    end
    // lines move on the falling edge, away from the sampling edge
    always @(negedge i_clk_sys) begin
        o_enable              <= i_en_req;
        o_segment_select_bit0 <= i_sel_req[0];
        o_segment_select_bit1 <= i_sel_req[1];
        o_segment_select_bit2 <= i_sel_req[2];
    end
endmodule : mss_ctrl_model

// ===== sim/mss_sequencer_test.sv
// self-checking bench for the multistage speed sequencer
`timescale 1ns/1ps
module mss_sequencer_test;
    logic                     clk, rst, en_req, en, b0, b1, b2;
    logic [2:0]               sel_req, cfg_idx, idx;
    logic                     cfg_wr, run, done;
    mss_pkg::mss_settings_t   st;
    mss_pkg::mss_ramp_times_t rt;
    mss_pkg::mss_seg_cfg_t    cfg;
    logic signed [15:0]       spd;
    int                       fails, compares, cyc, n;
    int sp[8] = '{-3000, 3000, 200, -300, 400, 500, 600, 700};

    // ms is 10 cycles here so run times stay short
    mss_sequencer #(.P_CYC_PER_MS(10)) mss_sequencer_i (.i_clk_sys(clk),
        .i_rst(rst), .i_enable(en), .i_segment_select_bit0(b0),
        .i_segment_select_bit1(b1), .i_segment_select_bit2(b2),
        .i_settings(st), .i_ramp_times(rt), .i_cfg_wr(cfg_wr),
        .i_cfg_index(cfg_idx), .i_cfg_data(cfg), .o_speed_cmd(spd),
        .o_segment_index(idx), .o_running(run), .o_sequence_done(done));
    mss_ctrl_model mss_ctrl_model_i (.i_clk_sys(clk), .i_en_req(en_req),
        .i_sel_req(sel_req), .o_enable(en), .o_segment_select_bit0(b0),
        .o_segment_select_bit1(b1), .o_segment_select_bit2(b2));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            fails++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk
    task automatic wr_seg(input int i, input int v, input int t, input int r);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_idx = i[2:0];
        cfg = '{v[15:0], t[14:0], r[1:0]};
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : wr_seg
    task automatic go(input logic [1:0] q, input logic [3:0] l,
                      input logic [1:0] u);
        @(negedge clk);
        st = '{4'h3, q, l, u};
    endtask : go
    // requests land in the model, which moves the lines on a falling edge
    task automatic ctrl(input logic e, input logic [2:0] s);
        @(posedge clk);
        en_req <= e;
        sel_req <= s;
        @(negedge clk);
    endtask : ctrl
    task automatic wait_idx(input logic [2:0] k, output int c);
        c = 0;
        while (idx !== k && c < 20000) begin
            @(negedge clk);
            c++;
        end
        chk(c < 20000, "segment never reached");
    endtask : wait_idx
    task automatic wait_done(output int c);
        c = 0;
        while (done !== 1'b1 && c < 20000) begin
            @(negedge clk);
            c++;
        end
    endtask : wait_done

    // ------------------------------------------------------------
    // clock, timeout, tests
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        {rst, en_req, sel_req, cfg_wr, cfg_idx} = 9'h100;
        st = '{4'h3, 2'h0, 4'h3, 2'h0};
        rt = '0;
        cfg = '0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        go(2'h2, 4'h1, 2'h0);
        ctrl(1'b1, 3'h5);
        repeat (4) @(negedge clk);
        chk(idx === 3'h5 && spd === 16'sh000a, "default table");
        for (int i = 0; i < 8; i++) wr_seg(i, sp[i], 2, 0);
        for (int v = 0; v < 8; v++) begin
            ctrl(1'b1, v[2:0]);
            repeat (4) @(negedge clk);
            chk(idx === v[2:0] && spd === sp[v][15:0], "select");
        end
        repeat (40) @(negedge clk);
        chk(idx === 3'h7 && run === 1'b1, "select hold");
        ctrl(1'b0, 3'h0);
        go(2'h0, 4'h3, 2'h0);
        st.drive_control_mode_setting = 4'h0;
        ctrl(1'b1, 3'h0);
        repeat (10) @(negedge clk);
        chk(run === 1'b0, "ran outside internal speed mode");
        st.drive_control_mode_setting = 4'h3;
        wait_idx(3'h1, n);
        wait_idx(3'h2, n);
        chk(n >= 20 && n <= 22, "segment length in ms");
        repeat (3) @(negedge clk);
        chk(spd === 16'sh00c8, "segment three speed");
        wait_done(n);
        repeat (40) @(negedge clk);
        chk(done === 1'b1 && run === 1'b0 && spd === 16'sh0000, "stop");
        ctrl(1'b0, 3'h0);
        go(2'h1, 4'h2, 2'h0);
        ctrl(1'b1, 3'h0);
        wait_idx(3'h1, n);
        wait_idx(3'h0, n);
        chk(n >= 20 && n <= 22 && run === 1'b1, "cyclic wrap");
        wait_idx(3'h1, n);
        ctrl(1'b0, 3'h0);
        repeat (3) @(negedge clk);
        chk(run === 1'b0, "enable drop");
        ctrl(1'b1, 3'h0);
        repeat (3) @(negedge clk);
        chk(run === 1'b1 && idx === 3'h0, "restart");
        ctrl(1'b0, 3'h0);
        wr_seg(0, 100, 1, 0);
        go(2'h0, 4'h1, 2'h1);
        ctrl(1'b1, 3'h0);
        wait_done(n);
        chk(n >= 9995 && n <= 10003, "second unit");
        ctrl(1'b0, 3'h0);
        // minute unit: still in the segment just past one second
        go(2'h0, 4'h1, 2'h2);
        ctrl(1'b1, 3'h0);
        repeat (10100) @(negedge clk);
        chk(run === 1'b1 && done === 1'b0, "minute unit");
        ctrl(1'b0, 3'h0);
        rt.accel = {14'h0384, 14'h0258, 14'h012c};
        rt.decel = {14'h0258, 14'h012c, 14'h0384};
        wr_seg(0, 300, 100, 2);
        wr_seg(1, 0, 100, 2);
        go(2'h0, 4'h2, 2'h0);
        ctrl(1'b1, 3'h0);
        repeat (300) @(negedge clk);
        chk(spd >= 145 && spd <= 155, "accel pair two");
        wait_idx(3'h1, n);
        repeat (150) @(negedge clk);
        chk(spd >= 145 && spd <= 155, "decel pair two");
        close_out();
    end
endmodule : mss_sequencer_test
